// file: hdl/ams_pkg.sv
// Purpose: shared constants, field layout and lookup values for the measurement scheduler
// Assumes: 16-bit configuration word, core clock of 100 MHz
// Notes: conversion times are kept in microseconds; cycle counts derive from them
package ams_pkg;
    // ==========================================================
    // configuration word layout
    localparam int CFG_W = 16;
    localparam int MODE_MSB = 15;
    localparam int MODE_LSB = 12;
    localparam int BUS_CT_MSB = 11;
    localparam int BUS_CT_LSB = 9;
    localparam int SHUNT_CT_MSB = 8;
    localparam int SHUNT_CT_LSB = 6;
    localparam int TEMP_CT_MSB = 5;
    localparam int TEMP_CT_LSB = 3;
    localparam int AVG_MSB = 2;
    localparam int AVG_LSB = 0;
    // mode bit 3 marks continuous, bits 2..0 enable temp, shunt, bus
    localparam int MODE_CONT_BIT = 3;
    localparam logic [3:0] MODE_SHUTDOWN = 4'h0;
    localparam logic [3:0] MODE_CONT_TEMP_SHUNT = 4'he;
    localparam logic [3:0] MODE_CONT_ALL = 4'hf;
    localparam logic [2:0] CT_RESET = 3'h5;
    localparam logic [2:0] AVG_RESET = 3'h0;
    localparam logic [CFG_W-1:0] CFG_RESET = {MODE_CONT_ALL, CT_RESET, CT_RESET, CT_RESET, AVG_RESET};

    // ==========================================================
    // channels, in conversion order
    localparam logic [1:0] CH_BUS = 2'h0;
    localparam logic [1:0] CH_SHUNT = 2'h1;
    localparam logic [1:0] CH_TEMP = 2'h2;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 100;
    localparam int TIMER_W = 20;
    localparam int AVG_CNT_W = 11;

    typedef enum logic {S_IDLE, S_CONV} ams_state_t;

    // conversion time in microseconds for time codes 0h to 7h
    localparam int CONV_US_CODE0 = 50;
    localparam int CONV_US_CODE1 = 84;
    localparam int CONV_US_CODE2 = 150;
    localparam int CONV_US_CODE3 = 280;
    localparam int CONV_US_CODE4 = 540;
    localparam int CONV_US_CODE5 = 1052;
    localparam int CONV_US_CODE6 = 2074;
    localparam int CONV_US_CODE7 = 4120;

    // samples per averaged result for averaging codes 0h to 7h
    localparam int AVG_N_CODE0 = 1;
    localparam int AVG_N_CODE1 = 4;
    localparam int AVG_N_CODE2 = 16;
    localparam int AVG_N_CODE3 = 64;
    localparam int AVG_N_CODE4 = 128;
    localparam int AVG_N_CODE5 = 256;
    localparam int AVG_N_CODE6 = 512;
    localparam int AVG_N_CODE7 = 1024;
endpackage : ams_pkg

// file: hdl/ams_adc_measurement_scheduler.sv
// Purpose: schedules bus, shunt and temperature conversions from the measurement config word
// Assumes: register writes arrive on core_clk from the serial host logic; front end converts while conv_active
// Notes: a config write restarts scheduling from the first enabled input; a write that enables no input parks it
`timescale 1ns/10ps
module ams_adc_measurement_scheduler #(
    parameter int CYCLES_PER_US = ams_pkg::CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cfg_wr_en,
    input wire logic [ams_pkg::CFG_W-1:0] cfg_wdata,
    output logic [ams_pkg::CFG_W-1:0] cfg_rdata,
    output logic conv_active,
    output logic [1:0] conv_channel,
    output logic sample_done,
    output logic result_update,
    output logic [1:0] result_channel
);
    import ams_pkg::*;

    // ==========================================================
    // state
    ams_state_t state;
    logic [CFG_W-1:0] cfg;
    logic start_req;
    logic [1:0] ch;
    logic [TIMER_W-1:0] timer;
    logic [AVG_CNT_W-1:0] samp;

    // lowest enabled input of a mask
    function automatic logic [1:0] lowest_set(input logic [2:0] m);
        if (m[CH_BUS]) begin
            lowest_set = CH_BUS;
        end else if (m[CH_SHUNT]) begin
            lowest_set = CH_SHUNT;
        end else begin
            lowest_set = CH_TEMP;
        end
    endfunction : lowest_set

    // inputs that come after a channel in conversion order
    function automatic logic [2:0] after_mask(input logic [1:0] c);
        case (c)
            CH_BUS: after_mask = 3'h6;
            CH_SHUNT: after_mask = 3'h4;
            default: after_mask = 3'h0;
        endcase
    endfunction : after_mask

    // conversion time in microseconds for a time code
    function automatic int conv_time_us(input logic [2:0] code);
        case (code)
            3'h0: conv_time_us = CONV_US_CODE0;
            3'h1: conv_time_us = CONV_US_CODE1;
            3'h2: conv_time_us = CONV_US_CODE2;
            3'h3: conv_time_us = CONV_US_CODE3;
            3'h4: conv_time_us = CONV_US_CODE4;
            3'h5: conv_time_us = CONV_US_CODE5;
            3'h6: conv_time_us = CONV_US_CODE6;
            default: conv_time_us = CONV_US_CODE7;
        endcase
    endfunction : conv_time_us

    // samples per averaged result for an averaging code
    function automatic int avg_samples(input logic [2:0] code);
        case (code)
            3'h0: avg_samples = AVG_N_CODE0;
            3'h1: avg_samples = AVG_N_CODE1;
            3'h2: avg_samples = AVG_N_CODE2;
            3'h3: avg_samples = AVG_N_CODE3;
            3'h4: avg_samples = AVG_N_CODE4;
            3'h5: avg_samples = AVG_N_CODE5;
            3'h6: avg_samples = AVG_N_CODE6;
            default: avg_samples = AVG_N_CODE7;
        endcase
    endfunction : avg_samples

    // ==========================================================
    // field decode
    wire [3:0] mode = cfg[MODE_MSB:MODE_LSB];
    wire [2:0] mode_mask = mode[2:0];
    wire mode_cont = mode[MODE_CONT_BIT];
    wire [2:0] bus_ct = cfg[BUS_CT_MSB:BUS_CT_LSB];
    wire [2:0] shunt_ct = cfg[SHUNT_CT_MSB:SHUNT_CT_LSB];
    wire [2:0] temp_ct = cfg[TEMP_CT_MSB:TEMP_CT_LSB];
    wire [2:0] avg_code = cfg[AVG_MSB:AVG_LSB];

    // per-channel time selection, and the one shared averaging count
    wire [2:0] ch_ct = (ch == CH_BUS) ? bus_ct : ((ch == CH_SHUNT) ? shunt_ct : temp_ct);
    wire [TIMER_W-1:0] conv_cycles = TIMER_W'(conv_time_us(ch_ct) * CYCLES_PER_US);
    wire [AVG_CNT_W-1:0] avg_last = AVG_CNT_W'(avg_samples(avg_code) - 1);

    // ==========================================================
    // sequencing terms
    // a pending restart outranks the end of a running conversion
    wire conv_end = (state == S_CONV) && !start_req && (timer == conv_cycles - TIMER_W'(1));
    wire avg_done = conv_end && (samp == avg_last);
    wire [2:0] later = mode_mask & after_mask(ch);
    wire have_next = |later;
    wire [1:0] first_ch = lowest_set(mode_mask);
    wire [1:0] later_ch = lowest_set(later);
    wire pass_end = avg_done && !have_next;

    // next state: shutdown codes park the scheduler, triggered codes stop after one pass
    wire start_run = start_req && (mode_mask != 3'h0);
    wire stop_run = (start_req && (mode_mask == 3'h0)) || (pass_end && !mode_cont);
    wire ams_state_t next_state = start_run ? S_CONV : (stop_run ? S_IDLE : state);
    wire [1:0] next_ch = start_req ? first_ch : (avg_done ? (have_next ? later_ch : first_ch) : ch);
    wire [TIMER_W-1:0] next_timer = (start_req || conv_end) ? '0 : timer + TIMER_W'(1);
    wire [AVG_CNT_W-1:0] next_samp = (start_req || avg_done) ? '0 : (conv_end ? samp + AVG_CNT_W'(1) : samp);

    // ==========================================================
    // configuration register; a write is acted on the cycle after it lands
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
            start_req <= 1'b0;
        end else begin
            if (cfg_wr_en) begin
                cfg <= cfg_wdata;
            end
            start_req <= cfg_wr_en;
        end
    end

    // scheduler registers; timer only advances while converting so idle power stays flat
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_IDLE;
            ch <= CH_BUS;
            timer <= '0;
            samp <= '0;
        end else begin
            state <= next_state;
            ch <= next_ch;
            timer <= (next_state == S_CONV) ? next_timer : '0;
            samp <= (next_state == S_CONV) ? next_samp : '0;
        end
    end

    // registered outputs; sample and result pulses trail the conversion end by one cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= CFG_RESET;
            conv_active <= 1'b0;
            conv_channel <= CH_BUS;
            sample_done <= 1'b0;
            result_update <= 1'b0;
            result_channel <= CH_BUS;
        end else begin
            cfg_rdata <= cfg_wr_en ? cfg_wdata : cfg;
            conv_active <= (next_state == S_CONV);
            conv_channel <= next_ch;
            sample_done <= conv_end;
            result_update <= avg_done;
            if (avg_done) begin
                result_channel <= ch;
            end
        end
    end

    // ==========================================================
    // checks: helper counters measure conversion length and samples per result
    logic [TIMER_W:0] hlp_len;
    logic [AVG_CNT_W:0] hlp_samps;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hlp_len <= '0;
            hlp_samps <= '0;
        end else begin
            hlp_len <= (start_req || conv_end || state != S_CONV) ? '0 : hlp_len + (TIMER_W+1)'(1);
            hlp_samps <= (start_req || avg_done) ? '0 : (conv_end ? hlp_samps + (AVG_CNT_W+1)'(1) : hlp_samps);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_write_shutdown;
        start_req && (mode_mask == 3'h0);
    endsequence

    sequence s_write_triggered;
        start_req && !mode_cont && (mode_mask != 3'h0);
    endsequence

    sequence s_write_all_cont;
        start_req && (mode == MODE_CONT_ALL);
    endsequence

    a_shutdown_parks: assert property (s_write_shutdown |=> !conv_active [*2])
        else $error("converter active after shutdown code");

    a_all_cont_order: assert property (s_write_all_cont ##1 (!start_req && !cfg_wr_en) [*2]
        |-> conv_active && conv_channel == CH_BUS && ch == CH_BUS)
        else $error("continuous all mode did not start on bus input");

    a_all_cont_loops: assert property ((mode == MODE_CONT_ALL) && pass_end |=> conv_active && ch == CH_BUS)
        else $error("continuous all mode did not wrap to bus input");

    a_e_skips_bus: assert property ((mode == MODE_CONT_TEMP_SHUNT) && state == S_CONV && !start_req
        |-> ch != CH_BUS && conv_channel != CH_BUS)
        else $error("bus converted in temperature and shunt mode");

    a_single_pass: assert property (pass_end && !mode_cont ##1 !start_req |-> !conv_active && state == S_IDLE)
        else $error("triggered mode kept converting after its pass");

    a_bus_time: assert property (conv_end && ch == CH_BUS
        |-> int'(hlp_len) + 1 == conv_time_us(cfg[BUS_CT_MSB:BUS_CT_LSB]) * CYCLES_PER_US)
        else $error("bus conversion length wrong");

    a_shunt_time: assert property (conv_end && ch == CH_SHUNT
        |-> int'(hlp_len) + 1 == conv_time_us(cfg[SHUNT_CT_MSB:SHUNT_CT_LSB]) * CYCLES_PER_US)
        else $error("shunt conversion length wrong");

    a_temp_time: assert property (conv_end && ch == CH_TEMP
        |-> int'(hlp_len) + 1 == conv_time_us(cfg[TEMP_CT_MSB:TEMP_CT_LSB]) * CYCLES_PER_US)
        else $error("temperature conversion length wrong");

    a_avg_complete: assert property (avg_done |-> int'(hlp_samps) + 1 == avg_samples(cfg[AVG_MSB:AVG_LSB]))
        else $error("result updated with wrong sample count");

    a_no_early_result: assert property (conv_end && int'(hlp_samps) + 1 < avg_samples(avg_code)
        |=> sample_done && !result_update)
        else $error("result updated before averaging finished");

    a_enabled_only: assert property (state == S_CONV && !start_req |-> mode_mask[ch])
        else $error("converting an input the mode does not enable");

    a_trigger_starts: assert property (s_write_triggered |=> conv_active && conv_channel == lowest_set(mode_mask))
        else $error("triggered write did not start a pass");

    // ==========================================================
    // checks: order of inputs inside a continuous pass and at its wrap to the next pass
    sequence s_all_bus_done;
        (mode == MODE_CONT_ALL) && avg_done && ch == CH_BUS;
    endsequence

    sequence s_all_shunt_done;
        (mode == MODE_CONT_ALL) && avg_done && ch == CH_SHUNT;
    endsequence

    sequence s_e_shunt_done;
        (mode == MODE_CONT_TEMP_SHUNT) && avg_done && ch == CH_SHUNT;
    endsequence

    sequence s_e_temp_done;
        (mode == MODE_CONT_TEMP_SHUNT) && avg_done && ch == CH_TEMP;
    endsequence

    a_all_bus_shunt: assert property (s_all_bus_done |=> conv_active && ch == CH_SHUNT)
        else $error("shunt did not follow bus in continuous all mode");

    a_all_shunt_temp: assert property (s_all_shunt_done |=> conv_active && ch == CH_TEMP)
        else $error("temperature did not follow shunt in continuous all mode");

    a_e_shunt_temp: assert property (s_e_shunt_done |=> conv_active && ch == CH_TEMP)
        else $error("temperature did not follow shunt in temperature and shunt mode");

    a_e_temp_shunt: assert property (s_e_temp_done |=> conv_active && ch == CH_SHUNT)
        else $error("temperature and shunt mode did not wrap to shunt");

    // a write landing at the pass end changes the mask, so the wrap is only judged without one
    a_cont_wraps: assert property (pass_end && mode_cont ##1 !start_req |-> conv_active && ch == first_ch)
        else $error("continuous mode stopped or wrapped to a wrong input");

    // ==========================================================
    // checks: register port, pulses and idle behaviour
    a_cfg_readback: assert property (cfg_wr_en |=> cfg_rdata == $past(cfg_wdata))
        else $error("config readback differs from the written word");

    // triggered modes must wait for software; nothing restarts on its own
    a_idle_holds: assert property (state == S_IDLE && !start_req |=> !conv_active)
        else $error("converter started with no write");

    // an aborted conversion must not leak a half-finished sample
    a_restart_quiet: assert property (start_req |=> !sample_done && !result_update)
        else $error("aborted conversion still reported a sample");

    a_sample_pulse: assert property (sample_done |=> !sample_done)
        else $error("sample done held longer than one cycle");

    a_result_pairs: assert property (result_update |-> sample_done)
        else $error("result update without its last sample");

    a_result_holds: assert property (!result_update |-> $stable(result_channel))
        else $error("result channel moved without a result update");

    a_single_sample: assert property (conv_end && avg_samples(avg_code) == 1 |=> result_update)
        else $error("result not updated after a single sample");
endmodule : ams_adc_measurement_scheduler

// file: verif/ams_front_end_model.sv
// Purpose: front end model that tallies finished bus conversions
// Assumes: sample_done follows each conversion by one cycle
// Notes: produces no data; the tally lets the bench see skipped inputs
`timescale 1ns/10ps
module ams_front_end_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic conv_active,
    input wire logic [1:0] conv_channel,
    input wire logic sample_done,
    output logic [15:0] bus_count
);
    logic [1:0] held_ch;
    // channel lags a cycle because conv_channel has moved on by the done pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_ch <= 2'h0;
            bus_count <= 16'h0;
        end else begin
            if (conv_active) begin
                held_ch <= conv_channel;
            end
            if (sample_done && held_ch == 2'h0) begin
                bus_count <= bus_count + 16'h1;
            end
        end
    end
endmodule : ams_front_end_model

// file: verif/tb_ams_adc_measurement_scheduler.sv
// Purpose: self-checking bench for the measurement scheduler
// Assumes: one microsecond shortened to one clock
// Notes: intervals are counted between sample_done pulses
`timescale 1ns/10ps
module tb_ams_adc_measurement_scheduler;
    import ams_pkg::*;
    localparam int CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    localparam int AVG_N [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    logic [15:0] b;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_wr_en = 1'b0;
    logic [15:0] cfg_wdata = 16'h0;
    logic [15:0] cfg_rdata, bus_count;
    logic conv_active, sample_done, result_update;
    logic [1:0] conv_channel, result_channel;
    always #5 core_clk = ~core_clk;
    ams_adc_measurement_scheduler #(.CYCLES_PER_US(1)) u_ams_adc_measurement_scheduler (.core_clk(core_clk),
        .rst_n(rst_n), .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .conv_active(conv_active), .conv_channel(conv_channel), .sample_done(sample_done),
        .result_update(result_update), .result_channel(result_channel));
    ams_front_end_model u_ams_front_end_model (.core_clk(core_clk), .rst_n(rst_n), .conv_active(conv_active),
        .conv_channel(conv_channel), .sample_done(sample_done), .bus_count(bus_count));
    // ==========================================================
    // tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] v);
        @(posedge core_clk);
        cfg_wr_en <= 1'b1;
        cfg_wdata <= v;
        @(posedge core_clk);
        cfg_wr_en <= 1'b0;
        #1;
    endtask : wr
    // expected order and spacing come from the fields of the word written
    task automatic run_pass(input logic [15:0] cfg, input int passes);
        int n;
        int first;
        int len [3];
        wr(cfg);
        len = '{CONV_US[cfg[11:9]], CONV_US[cfg[8:6]], CONV_US[cfg[5:3]]};
        // the write edge, then one cycle to start, precede the first conversion
        first = 1;
        for (int p = 0; p < passes; p++) begin
            for (int c = 0; c < 3; c++) begin
                if (cfg[12+c]) begin
                    for (int s = 1; s <= AVG_N[cfg[2:0]]; s++) begin
                        n = 0;
                        do begin
                            @(posedge core_clk);
                            #1;
                            n++;
                        end while (sample_done !== 1'b1 && n < 5000);
                        check(n[15:0], 16'(len[c] + first), "interval");
                        first = 0;
                        check({15'h0, result_update}, {15'h0, s == AVG_N[cfg[2:0]]}, "update");
                        if (s == AVG_N[cfg[2:0]]) begin
                            check({14'h0, result_channel}, c[15:0], "result ch");
                        end
                    end
                end
            end
        end
        repeat (3) @(posedge core_clk);
        #1;
        check({15'h0, conv_active}, {15'h0, cfg[15]}, "after pass");
        check(cfg_rdata, cfg, "readback");
    endtask : run_pass
    task automatic end_test(input string name);
        $display("test %s done, checks %0d", name, checks);
    endtask : end_test
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // ==========================================================
    // hang guard, well above the roughly 15k cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            $display("MISMATCH t=%0t timeout", $time);
            print_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check(cfg_rdata, 16'hfb68, "reset word");
        repeat (30) @(posedge core_clk);
        #1;
        check({15'h0, conv_active}, 16'h0, "no autostart");
        end_test("reset");
        for (int k = 0; k < 8; k++) run_pass({4'h1, k[2:0], 9'h0}, 1);
        run_pass(16'h7298, 1);
        end_test("times");
        for (int m = 1; m < 8; m++) run_pass({m[3:0], 12'h0}, 1);
        for (int m = 9; m < 16; m++) run_pass({m[3:0], 12'h0}, 2);
        b = bus_count;
        run_pass(16'he000, 2);
        check(bus_count, b, "bus skipped");
        end_test("modes");
        run_pass(16'h3001, 1);
        run_pass(16'h1003, 1);
        end_test("averaging");
        // a write in mid conversion must restart timing from that write
        wr(16'hf000);
        repeat (20) @(posedge core_clk);
        run_pass(16'h1000, 1);
        for (int m = 0; m < 2; m++) begin
            wr(16'hf000);
            wr({m[0], 15'h0});
            repeat (60) @(posedge core_clk);
            #1;
            check({15'h0, conv_active}, 16'h0, "shutdown");
        end
        end_test("restart and shutdown");
        print_verdict;
    end
endmodule : tb_ams_adc_measurement_scheduler
